/* File: rtl/ppol_top.sv */
// Pulse pattern output latch: APB registers, trigger selection, pins
//
// How it works
// - Eight outputs form group 2 and group 3 of four bits, each with its own trigger.
// - Group 3 drives pattern pins 15 to 12 and group 2 drives pins 11 to 8.
// - Two 8-bit read/write enable registers switch trigger transfer per bit; only the high one also switches pin output.
// - A pin shows its pattern bit only when its enable bit and direction bit are 1.
// - A trigger copies each enabled next-pattern bit into its output level bit.
// - Output level bits whose enable is clear keep their value on a trigger.
// - Output level registers are 8 bits; the high one holds the levels being presented on pins 15 to 8.
// - An enabled output level bit ignores CPU writes and changes only by trigger.
// - A disabled output level bit accepts CPU writes to preset its level.
// - Enable and output level registers read 0 after reset.
// - Two 8-bit read/write next-pattern registers hold the next pattern.
// - The low output level register works like the high one, but the group 2 trigger transfers both of its nibbles.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module ppol_top
#(
   parameter int CM_N = ppol_pkg::PPOL_CM_N
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ppol_pkg::PPOL_AW-1:0] paddr,
   input wire logic [ppol_pkg::PPOL_DW-1:0] pwdata,
   output logic [ppol_pkg::PPOL_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer compare-match events
   input wire logic [CM_N-1:0] compare_match,
   // Port direction bits of pins 15 to 8
   input wire logic [7:0] port_dir,
   // Pattern pins 15 to 8
   output logic [7:0] pattern_out,
   output logic [7:0] pattern_oe
);

   // ************************************************************
   // Decoding helpers
   // ************************************************************
   function automatic logic addr_is
   (
      input logic [ppol_pkg::PPOL_AW-1:0] a,
      input logic [7:0] off
   );
      addr_is = (a == off);
   endfunction : addr_is

   function automatic logic pick_line
   (
      input logic [CM_N-1:0] lines,
      input logic [ppol_pkg::PPOL_SEL_W-1:0] sel
   );
      pick_line = (32'(sel) < CM_N) ? lines[sel] : 1'b0;
   endfunction : pick_line

   // ************************************************************
   // Declarations
   // ************************************************************
   ppol_pkg::ppol_state_t state_reg;
   ppol_pkg::ppol_state_t state_next;
   logic [7:0] out_ctrl_reg;
   logic [7:0] out_mode_reg;
   logic [7:0] nen_high_reg;
   logic [7:0] nen_low_reg;
   logic [7:0] npat_high_reg;
   logic [7:0] npat_low_reg;
   logic [ppol_pkg::PPOL_DW-1:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [7:0] pat_out_reg;
   logic [7:0] pat_oe_reg;
   logic cm_g2_prev_reg;
   logic cm_g3_prev_reg;
   logic [7:0] lvl_high;
   logic [7:0] lvl_low;
   logic hit_ctrl;
   logic hit_mode;
   logic hit_nen_h;
   logic hit_nen_l;
   logic hit_lvl_h;
   logic hit_lvl_l;
   logic hit_npat_h;
   logic hit_npat_l;
   logic hit_any;
   logic commit;
   logic wr_commit;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   logic cm_g2;
   logic cm_g3;
   logic trig_g2;
   logic trig_g3;
   logic [3:0] nib_trig;
   logic [3:0] nib_wr;
   logic [15:0] all_en;
   logic [15:0] all_nxt;
   logic [15:0] all_lvl;

   // ************************************************************
   // Address decode
   // ************************************************************
   assign hit_ctrl = addr_is(paddr, ppol_pkg::PPOL_OFF_OUT_CTRL);
   assign hit_mode = addr_is(paddr, ppol_pkg::PPOL_OFF_OUT_MODE);
   assign hit_nen_h = addr_is(paddr, ppol_pkg::PPOL_OFF_NEN_HIGH);
   assign hit_nen_l = addr_is(paddr, ppol_pkg::PPOL_OFF_NEN_LOW);
   assign hit_lvl_h = addr_is(paddr, ppol_pkg::PPOL_OFF_LVL_HIGH);
   assign hit_lvl_l = addr_is(paddr, ppol_pkg::PPOL_OFF_LVL_LOW);
   assign hit_npat_h = addr_is(paddr, ppol_pkg::PPOL_OFF_NPAT_HIGH);
   assign hit_npat_l = addr_is(paddr, ppol_pkg::PPOL_OFF_NPAT_LOW);
   assign hit_any = hit_ctrl | hit_mode | hit_nen_h | hit_nen_l |
      hit_lvl_h | hit_lvl_l | hit_npat_h | hit_npat_l;

   // ************************************************************
   // Read selection
   // ************************************************************
   // Upper 24 bits always read as zero
   assign rd_byte = hit_ctrl ? out_ctrl_reg :
      hit_mode ? out_mode_reg :
      hit_nen_h ? nen_high_reg :
      hit_nen_l ? nen_low_reg :
      hit_lvl_h ? lvl_high :
      hit_lvl_l ? lvl_low :
      hit_npat_h ? npat_high_reg :
      hit_npat_l ? npat_low_reg :
      ppol_pkg::PPOL_RST_BYTE;

   // ************************************************************
   // Bus answer sequence
   // ************************************************************
   // Fixed two-cycle access phase; writes land when pready is seen
   assign commit = (state_reg == ppol_pkg::PPOL_DONE) & psel & penable;
   assign wr_commit = commit & pwrite & hit_any;
   assign wbyte = pwdata[7:0];

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ppol_pkg::PPOL_IDLE:
         begin
            if (psel)
            begin
               state_next = ppol_pkg::PPOL_WAIT;
            end
         end
         ppol_pkg::PPOL_WAIT:
         begin
            if (psel & penable)
            begin
               state_next = ppol_pkg::PPOL_DONE;
            end
            else if (!psel)
            begin
               state_next = ppol_pkg::PPOL_IDLE;
            end
         end
         ppol_pkg::PPOL_DONE:
         begin
            state_next = ppol_pkg::PPOL_IDLE;
         end
         default:
         begin
            state_next = ppol_pkg::PPOL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ppol_pkg::PPOL_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= ppol_pkg::PPOL_RST_WORD;
      end
      else
      begin
         pready_reg <= (state_reg == ppol_pkg::PPOL_WAIT) & psel & penable;
         pslverr_reg <= (state_reg == ppol_pkg::PPOL_WAIT) & psel & penable & ~hit_any;
         if ((state_reg == ppol_pkg::PPOL_WAIT) & psel & penable)
         begin
            prdata_reg <= {24'h000000, rd_byte};
         end
      end
   end

   // ************************************************************
   // Plain read/write registers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_ctrl_reg <= ppol_pkg::PPOL_RST_BYTE;
         out_mode_reg <= ppol_pkg::PPOL_RST_BYTE;
      end
      else
      begin
         if (wr_commit & hit_ctrl)
         begin
            out_ctrl_reg <= wbyte;
         end
         if (wr_commit & hit_mode)
         begin
            out_mode_reg <= wbyte;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nen_high_reg <= ppol_pkg::PPOL_RST_BYTE;
         nen_low_reg <= ppol_pkg::PPOL_RST_BYTE;
      end
      else
      begin
         if (wr_commit & hit_nen_h)
         begin
            nen_high_reg <= wbyte;
         end
         if (wr_commit & hit_nen_l)
         begin
            nen_low_reg <= wbyte;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         npat_high_reg <= ppol_pkg::PPOL_RST_BYTE;
         npat_low_reg <= ppol_pkg::PPOL_RST_BYTE;
      end
      else
      begin
         if (wr_commit & hit_npat_h)
         begin
            npat_high_reg <= wbyte;
         end
         if (wr_commit & hit_npat_l)
         begin
            npat_low_reg <= wbyte;
         end
      end
   end

   // ************************************************************
   // Output triggers
   // ************************************************************
   // Edge taken so a held match line cannot retrigger
   assign cm_g2 = pick_line(compare_match,
      out_ctrl_reg[ppol_pkg::PPOL_G2_SEL_LSB +: ppol_pkg::PPOL_SEL_W]);
   assign cm_g3 = pick_line(compare_match,
      out_ctrl_reg[ppol_pkg::PPOL_G3_SEL_LSB +: ppol_pkg::PPOL_SEL_W]);
   assign trig_g2 = cm_g2 & ~cm_g2_prev_reg;
   assign trig_g3 = cm_g3 & ~cm_g3_prev_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cm_g2_prev_reg <= 1'b0;
         cm_g3_prev_reg <= 1'b0;
      end
      else
      begin
         cm_g2_prev_reg <= cm_g2;
         cm_g3_prev_reg <= cm_g3;
      end
   end

   // ************************************************************
   // Level latch slices
   // ************************************************************
   // Slice 3 is group 3, slice 2 is group 2; low byte slices follow group 2
   assign nib_trig = {trig_g3, trig_g2, trig_g2, trig_g2};
   assign nib_wr = {{2{wr_commit & hit_lvl_h}}, {2{wr_commit & hit_lvl_l}}};
   assign all_en = {nen_high_reg, nen_low_reg};
   assign all_nxt = {npat_high_reg, npat_low_reg};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_slice
         ppol_pkg::ppol_nib_ctl_t slice_ctl;
         assign slice_ctl.trig = nib_trig[gi];
         assign slice_ctl.en = all_en[gi*4 +: 4];
         assign slice_ctl.nxt = all_nxt[gi*4 +: 4];
         assign slice_ctl.wr = nib_wr[gi];
         assign slice_ctl.wdata = pwdata[(gi%2)*4 +: 4];
         ppol_latch u_latch
         (
            .clk(clk),
            .rst_n(rst_n),
            .ctl(slice_ctl),
            .level(all_lvl[gi*4 +: 4])
         );
      end
   endgenerate

   assign lvl_high = all_lvl[15:8];
   assign lvl_low = all_lvl[7:0];

   // ************************************************************
   // Pattern pins
   // ************************************************************
   // Group 3 on bits 7:4 (pins 15..12), group 2 on bits 3:0 (pins 11..8)
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pat_out_reg <= ppol_pkg::PPOL_RST_BYTE;
         pat_oe_reg <= ppol_pkg::PPOL_RST_BYTE;
      end
      else
      begin
         pat_out_reg <= lvl_high & nen_high_reg & port_dir;
         pat_oe_reg <= nen_high_reg & port_dir;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign pattern_out = pat_out_reg;
   assign pattern_oe = pat_oe_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

endmodule : ppol_top

`default_nettype wire

/* File: include/ppol_pkg.sv */
// Shared constants and types of the pulse pattern output latch
package ppol_pkg;

   // ************************************************************
   // Bus and data widths
   // ************************************************************
   localparam int PPOL_DW = 32;
   localparam int PPOL_AW = 8;
   localparam int PPOL_RW = 8;
   localparam int PPOL_NIB_W = 4;
   localparam int PPOL_CM_N = 4;
   localparam int PPOL_SEL_W = 2;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] PPOL_OFF_OUT_CTRL = 8'h00;
   localparam logic [7:0] PPOL_OFF_OUT_MODE = 8'h04;
   localparam logic [7:0] PPOL_OFF_NEN_HIGH = 8'h08;
   localparam logic [7:0] PPOL_OFF_NEN_LOW = 8'h0C;
   localparam logic [7:0] PPOL_OFF_LVL_HIGH = 8'h10;
   localparam logic [7:0] PPOL_OFF_LVL_LOW = 8'h14;
   localparam logic [7:0] PPOL_OFF_NPAT_HIGH = 8'h18;
   localparam logic [7:0] PPOL_OFF_NPAT_LOW = 8'h1C;

   // ************************************************************
   // Field positions of the output control register
   // ************************************************************
   localparam int PPOL_G2_SEL_LSB = 0;
   localparam int PPOL_G3_SEL_LSB = 2;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] PPOL_RST_BYTE = 8'h00;
   localparam logic [31:0] PPOL_RST_WORD = 32'h00000000;

   // ************************************************************
   // Bus answer states
   // ************************************************************
   typedef enum logic [2:0]
   {
      PPOL_IDLE = 3'b001,
      PPOL_WAIT = 3'b010,
      PPOL_DONE = 3'b100
   } ppol_state_t;

   // ************************************************************
   // Control bundle for one 4-bit latch slice
   // ************************************************************
   typedef struct packed
   {
      logic trig;
      logic [PPOL_NIB_W-1:0] en;
      logic [PPOL_NIB_W-1:0] nxt;
      logic wr;
      logic [PPOL_NIB_W-1:0] wdata;
   } ppol_nib_ctl_t;

endpackage : ppol_pkg

/* File: rtl/ppol_latch.sv */
// One 4-bit slice of output levels with trigger transfer and CPU preset
`timescale 1ns/100ps
`default_nettype none

module ppol_latch
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire ppol_pkg::ppol_nib_ctl_t ctl,
   // Held levels
   output logic [ppol_pkg::PPOL_NIB_W-1:0] level
);

   logic [ppol_pkg::PPOL_NIB_W-1:0] level_reg;
   logic [ppol_pkg::PPOL_NIB_W-1:0] level_next;
   logic [ppol_pkg::PPOL_NIB_W-1:0] en_part;
   logic [ppol_pkg::PPOL_NIB_W-1:0] dis_part;

   // ************************************************************
   // Next value
   // ************************************************************
   // Enabled bits follow the trigger and ignore the CPU
   assign en_part = ctl.trig ? ctl.nxt : level_reg;
   // Disabled bits hold on a trigger and take CPU presets
   assign dis_part = ctl.wr ? ctl.wdata : level_reg;
   assign level_next = (ctl.en & en_part) | (~ctl.en & dis_part);

   // ************************************************************
   // Storage
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level_reg <= ppol_pkg::PPOL_RST_BYTE[ppol_pkg::PPOL_NIB_W-1:0];
      end
      else
      begin
         level_reg <= level_next;
      end
   end

   assign level = level_reg;

endmodule : ppol_latch

`default_nettype wire

/* File: sim/ppol_top_sva.sv */
// Assertion checker for the pulse pattern output latch
`timescale 1ns/100ps
`default_nettype none

module ppol_top_sva
#(
   parameter int CM_N = 4
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events and pins
   input wire logic [CM_N-1:0] compare_match,
   input wire logic [7:0] port_dir,
   input wire logic [7:0] pattern_out,
   input wire logic [7:0] pattern_oe
);
   // ****************************************
   // Causes of a pin change
   // ****************************************
   logic [CM_N-1:0] cm_reg;
   logic cause;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cm_reg <= '0;
      else
         cm_reg <= compare_match;
   end
   // Any rising line counts; too loose for selection, tight for stray updates
   assign cause = (|(compare_match & ~cm_reg)) | (psel & penable & pready & pwrite);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_oe_needs_dir: assert property ((pattern_oe & ~$past(port_dir)) == 8'h00)
      else $error("pin enabled without direction");
   a_out_needs_oe: assert property ((pattern_out & ~pattern_oe) == 8'h00)
      else $error("pin level shown while not driven");
   a_pin_cause: assert property ($changed(pattern_out) |->
      $past(cause, 2) || ($past(port_dir) != $past(port_dir, 2)))
      else $error("pin changed without trigger or write");
   a_oe_cause: assert property ($changed(pattern_oe) |->
      $past(psel & pwrite & pready, 2) || ($past(port_dir) != $past(port_dir, 2)))
      else $error("pin enable changed without cause");
   a_reset_zero: assert property ($rose(rst_n) |-> (pattern_out | pattern_oe) == 8'h00)
      else $error("pins not zero after reset");
   a_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("read data above byte not zero");
   a_ready_time: assert property (psel && !penable |-> ##2 pready)
      else $error("access not answered in two cycles");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   c_trig: cover property (|(compare_match & ~cm_reg));
   c_err: cover property (pready && pslverr);
   c_drive: cover property (pattern_oe != 8'h00);
endmodule : ppol_top_sva

bind ppol_top ppol_top_sva #(.CM_N(CM_N)) u_ppol_top_sva (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_match(compare_match),
   .port_dir(port_dir), .pattern_out(pattern_out), .pattern_oe(pattern_oe));

`default_nettype wire

/* File: sim/ppol_load.sv */
// Model of the external loads on the pattern pins
`timescale 1ns/100ps
`default_nettype none

module ppol_load
(
   // Pins from the latch
   input wire logic [7:0] pattern_out,
   input wire logic [7:0] pattern_oe,
   // Levels seen on the board
   output logic [7:0] pin_level
);
   // Undriven pins fall to their pull-down
   assign pin_level = pattern_out & pattern_oe;
endmodule : ppol_load

`default_nettype wire

/* File: sim/ppol_top_bench.sv */
// Self-checking testbench of the pulse pattern output latch
`timescale 1ns/100ps
`default_nettype none

module ppol_top_bench;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, port_dir, pattern_out, pattern_oe, pin_level;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] compare_match;
   int num_errors = 0;
   int n_tests = 0;

   ppol_top #(.CM_N(4)) u_ppol_top (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .compare_match(compare_match),
      .port_dir(port_dir), .pattern_out(pattern_out), .pattern_oe(pattern_oe));
   ppol_load u_ppol_load (.pattern_out(pattern_out), .pattern_oe(pattern_oe),
      .pin_level(pin_level));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // Waits for pready with no bound of its own; the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      check("pready_wait", n, 32'h00000002);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check(name, rd, {24'h000000, exp});
   endtask : rchk

   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      compare_match <= m;
      @(posedge clk);
      compare_match <= 4'h0;
      repeat (3) @(posedge clk);
   endtask : pulse

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rchk("nen_h", ppol_pkg::PPOL_OFF_NEN_HIGH, 8'h00);
      rchk("nen_l", ppol_pkg::PPOL_OFF_NEN_LOW, 8'h00);
      rchk("lvl_h", ppol_pkg::PPOL_OFF_LVL_HIGH, 8'h00);
      rchk("lvl_l", ppol_pkg::PPOL_OFF_LVL_LOW, 8'h00);
      check("oe", pattern_oe, 32'h00000000);
   endtask : t_reset

   task automatic t_trigger();
      apb(1'b1, ppol_pkg::PPOL_OFF_LVL_HIGH, 8'hA5);
      rchk("preset_h", ppol_pkg::PPOL_OFF_LVL_HIGH, 8'hA5);
      apb(1'b1, ppol_pkg::PPOL_OFF_LVL_LOW, 8'h3C);
      rchk("preset_l", ppol_pkg::PPOL_OFF_LVL_LOW, 8'h3C);
      check("oe_off", pattern_out | pattern_oe, 32'h00000000);
      apb(1'b1, ppol_pkg::PPOL_OFF_NPAT_HIGH, 8'h5A);
      apb(1'b1, ppol_pkg::PPOL_OFF_NPAT_LOW, 8'hF0);
      apb(1'b1, ppol_pkg::PPOL_OFF_NEN_HIGH, 8'h0F);
      apb(1'b1, ppol_pkg::PPOL_OFF_NEN_LOW, 8'h0F);
      // Group 2 on line 1, group 3 on line 2
      apb(1'b1, ppol_pkg::PPOL_OFF_OUT_CTRL, 8'h09);
      rchk("npat_h", ppol_pkg::PPOL_OFF_NPAT_HIGH, 8'h5A);
      rchk("nen_l", ppol_pkg::PPOL_OFF_NEN_LOW, 8'h0F);
      pulse(4'h2);
      rchk("trig_h", ppol_pkg::PPOL_OFF_LVL_HIGH, (8'hA5 & 8'hF0) | (8'h5A & 8'h0F));
      rchk("trig_l", ppol_pkg::PPOL_OFF_LVL_LOW, (8'h3C & 8'hF0) | (8'hF0 & 8'h0F));
      check("oe", pattern_oe, 32'h0000000F);
      check("pins", pattern_out, 32'h0000000A);
      check("board", pin_level, 32'h0000000A);
      @(posedge clk);
      port_dir <= 8'hF7;
      repeat (3) @(posedge clk);
      check("dir_off", pattern_out, 32'h00000002);
      check("board_off", pin_level, 32'h00000002);
      port_dir <= 8'hFF;
      apb(1'b1, ppol_pkg::PPOL_OFF_LVL_HIGH, 8'hFF);
      rchk("ro", ppol_pkg::PPOL_OFF_LVL_HIGH, (8'hAA & 8'h0F) | (8'hFF & 8'hF0));
      apb(1'b1, ppol_pkg::PPOL_OFF_LVL_LOW, 8'hFF);
      rchk("ro_l", ppol_pkg::PPOL_OFF_LVL_LOW, (8'h30 & 8'h0F) | (8'hFF & 8'hF0));
   endtask : t_trigger

   task automatic t_groups();
      apb(1'b1, ppol_pkg::PPOL_OFF_NEN_HIGH, 8'hFF);
      apb(1'b1, ppol_pkg::PPOL_OFF_NPAT_HIGH, 8'h3C);
      pulse(4'h4);
      rchk("g3", ppol_pkg::PPOL_OFF_LVL_HIGH, (8'h3C & 8'hF0) | (8'hFA & 8'h0F));
      check("g3_pins", pattern_out, 32'h0000003A);
      pulse(4'h1);
      rchk("unsel", ppol_pkg::PPOL_OFF_LVL_HIGH, 8'h3A);
      apb(1'b1, ppol_pkg::PPOL_OFF_NPAT_HIGH, 8'hC5);
      pulse(4'h6);
      rchk("both", ppol_pkg::PPOL_OFF_LVL_HIGH, 8'hC5);
      // Line held high must not retrigger
      compare_match <= 4'h2;
      apb(1'b1, ppol_pkg::PPOL_OFF_NPAT_HIGH, 8'h96);
      rchk("held", ppol_pkg::PPOL_OFF_LVL_HIGH, 8'hC5);
      compare_match <= 4'h0;
   endtask : t_groups

   task automatic t_unmapped();
      apb(1'b1, 8'h20, 8'hFF);
      check("err_wr", {31'h00000000, err}, 32'h00000001);
      rchk("unmap", 8'h20, 8'h00);
      check("err_rd", {31'h00000000, err}, 32'h00000001);
      rchk("ctrl", ppol_pkg::PPOL_OFF_OUT_CTRL, 8'h09);
      apb(1'b1, ppol_pkg::PPOL_OFF_OUT_MODE, 8'h81);
      rchk("mode", ppol_pkg::PPOL_OFF_OUT_MODE, 8'h81);
   endtask : t_unmapped

   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      compare_match = 4'h0;
      port_dir = 8'hFF;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_trigger();
      t_groups();
      t_unmapped();
      end_sim();
   end

   // Run needs fewer than 200 cycles
   initial
   begin
      #(25 * 4000);
      num_errors++;
      end_sim();
   end
endmodule : ppol_top_bench

`default_nettype wire
